// ==== verilog/hsps_top.sv ====
// Host serial port select: pin routing, two UARTs, SPI slave and I2C slave.
// Assumes pins arrive asynchronously; open-drain levels are resolved outside.
`timescale 1ns/1ps
// How it works
// - Primary UART active when select pin high at reset.
// - UARTs carry no flow control signals.
// - Bit rate configurable within 9600..921600.
// - Transmit bit timing within one percent.
// - Receiver tolerates 2.5 percent rate error.
// - SPI inactive after reset unless selected.
// - Shared pins go to SPI when select low at reset.
// - SPI is slave only, never drives clock.
// - SPI mode zero, sample on rising edge.
// - I2C target only, up to 400 kbit/s.
// - Clock stretch lasts at most 20 ms.
// - Data bit set up before stretch release.
// - I2C off whenever SPI is selected.
// - USB full-speed port always offered.
// - UARTs default to 38400 8N1 after reset.
module hsps_top import hsps_pkg::*; #(
	parameter logic [6:0] I2C_ADDR = I2C_ADDR_DEF,
	parameter int STRETCH_CYC = I2C_STRETCH_CYC_DEF
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic host_sel_i,
	input wire logic pin_rxd_mosi_i,
	output logic pin_txd_miso_o,
	output logic pin_txd_miso_oe_o,
	input wire logic pin_scl_sck_i,
	output logic pin_scl_sck_o,
	output logic pin_scl_sck_oe_o,
	input wire logic pin_sda_cs_i,
	output logic pin_sda_cs_o,
	output logic pin_sda_cs_oe_o,
	input wire logic sec_rxd_i,
	output logic sec_txd_o,
	input wire logic [DIV_W-1:0] prim_div_i,
	input wire logic prim_div_load_i,
	input wire logic [DIV_W-1:0] sec_div_i,
	input wire logic sec_div_load_i,
	input wire logic prim_tx_valid_i,
	input wire logic [7:0] prim_tx_data_i,
	output logic prim_tx_ready_o,
	output logic prim_rx_valid_o,
	output logic [7:0] prim_rx_data_o,
	output logic prim_frame_err_o,
	input wire logic sec_tx_valid_i,
	input wire logic [7:0] sec_tx_data_i,
	output logic sec_tx_ready_o,
	output logic sec_rx_valid_o,
	output logic [7:0] sec_rx_data_o,
	output logic sec_frame_err_o,
	input wire logic i2c_tx_valid_i,
	input wire logic [7:0] i2c_tx_data_i,
	output logic i2c_tx_ready_o,
	output logic i2c_rx_valid_o,
	output logic [7:0] i2c_rx_data_o,
	output logic spi_mode_o,
	output logic usb_enable_o
);
	localparam int TMO_W = $clog2(STRETCH_CYC + 1);
	localparam logic [TMO_W-1:0] TMO_LIMIT = TMO_W'(STRETCH_CYC - int'(I2C_SETUP_CYC));
	localparam int SY_SEL = 0;
	localparam int SY_RXD = 1;
	localparam int SY_SCL = 2;
	localparam int SY_SDA = 3;
	localparam int SY_SEC = 4;

	typedef enum logic [3:0] {
		I_IDLE, I_ADDR, I_AACK, I_WRITE, I_WACK, I_LOAD, I_SETUP, I_READ, I_RACK
	} hsps_i2c_e;

	typedef struct packed {
		logic [4:0] s1;
		logic [4:0] s2;
		logic sel_uart;
		logic usb_en;
		hsps_i2c_e i2c;
		logic scl_prev;
		logic sda_prev;
		logic [3:0] bit_cnt;
		logic [7:0] sh;
		logic rw;
		logic ack_ok;
		logic sda_oe;
		logic scl_oe;
		logic [TMO_W-1:0] tmo;
		logic [3:0] setup;
		logic rx_valid;
		logic [7:0] rx_data;
	} hsps_top_s;

	hsps_top_s st_reg;
	hsps_top_s st_next;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic i2c_start;
	logic i2c_stop;
	logic i2c_take;
	logic u1_txd;
	logic u2_txd;
	logic miso;
	logic miso_oe;

	hsps_byte_if prim_bus();
	hsps_byte_if sec_bus();
	hsps_byte_if spi_bus();

	always_comb begin
		scl = st_reg.s2[SY_SCL];
		sda = st_reg.s2[SY_SDA];
		scl_rise = scl && !st_reg.scl_prev;
		scl_fall = !scl && st_reg.scl_prev;
		i2c_start = scl && st_reg.scl_prev && st_reg.sda_prev && !sda;
		i2c_stop = scl && st_reg.scl_prev && !st_reg.sda_prev && sda;
		i2c_take = st_reg.i2c == I_LOAD && (i2c_tx_valid_i || st_reg.tmo >= TMO_LIMIT);
		st_next = st_reg;
		st_next.s1 = {sec_rxd_i, pin_sda_cs_i, pin_scl_sck_i, pin_rxd_mosi_i, host_sel_i};
		st_next.s2 = st_reg.s1;
		st_next.scl_prev = scl;
		st_next.sda_prev = sda;
		st_next.rx_valid = 1'b0;
		if (!st_reg.sel_uart || i2c_stop) begin
			st_next.i2c = I_IDLE;
			st_next.sda_oe = 1'b0;
			st_next.scl_oe = 1'b0;
		end else if (i2c_start) begin
			st_next.i2c = I_ADDR;
			st_next.bit_cnt = '0;
			st_next.sda_oe = 1'b0;
			st_next.scl_oe = 1'b0;
		end else begin
			case (st_reg.i2c)
				I_ADDR, I_WRITE: begin
					if (scl_rise) begin
						st_next.sh = {st_reg.sh[6:0], sda};
						st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
					end else if (scl_fall && st_reg.bit_cnt == BYTE_BITS) begin
						if (st_reg.i2c == I_WRITE) begin
							st_next.sda_oe = 1'b1;
							st_next.rx_valid = 1'b1;
							st_next.rx_data = st_reg.sh;
							st_next.i2c = I_WACK;
						end else if (st_reg.sh[7:1] == I2C_ADDR) begin
							st_next.sda_oe = 1'b1;
							st_next.rw = st_reg.sh[0];
							st_next.i2c = I_AACK;
						end else begin
							st_next.i2c = I_IDLE;
						end
					end
				end
				I_AACK, I_WACK: begin
					if (scl_fall) begin
						st_next.sda_oe = 1'b0;
						st_next.bit_cnt = '0;
						st_next.tmo = '0;
						st_next.scl_oe = st_reg.rw && st_reg.i2c == I_AACK;
						st_next.i2c = (st_reg.rw && st_reg.i2c == I_AACK) ? I_LOAD : I_WRITE;
					end
				end
				I_LOAD: begin
					// SCL held low until a byte is offered or the stretch limit comes
					st_next.tmo = st_reg.tmo + 1'b1;
					if (i2c_take) begin
						st_next.sh = i2c_tx_valid_i ? i2c_tx_data_i : IDLE_BYTE;
						st_next.sda_oe = i2c_tx_valid_i ? !i2c_tx_data_i[BYTE_MSB] : 1'b0;
						st_next.setup = I2C_SETUP_CYC;
						st_next.i2c = I_SETUP;
					end
				end
				I_SETUP: begin
					st_next.setup = st_reg.setup - 1'b1;
					if (st_reg.setup == 4'h1) begin
						st_next.scl_oe = 1'b0;
						st_next.bit_cnt = '0;
						st_next.i2c = I_READ;
					end
				end
				I_READ: begin
					if (scl_fall) begin
						if (st_reg.bit_cnt == 4'(BYTE_MSB)) begin
							st_next.sda_oe = 1'b0;
							st_next.i2c = I_RACK;
						end else begin
							st_next.sh = {st_reg.sh[6:0], 1'b1};
							st_next.sda_oe = !st_reg.sh[6];
							st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
						end
					end
				end
				I_RACK: begin
					if (scl_rise) begin
						st_next.ack_ok = !sda;
					end else if (scl_fall) begin
						st_next.tmo = '0;
						st_next.scl_oe = st_reg.ack_ok;
						st_next.i2c = st_reg.ack_ok ? I_LOAD : I_IDLE;
					end
				end
				default: begin
					st_next.i2c = I_IDLE;
				end
			endcase
		end
		if (!reset_n_i) begin
			st_next = '0;
			st_next.s1 = {sec_rxd_i, pin_sda_cs_i, pin_scl_sck_i, pin_rxd_mosi_i, host_sel_i};
			st_next.s2 = st_reg.s1;
			st_next.sel_uart = st_reg.s2[SY_SEL];
			st_next.usb_en = 1'b1;
			st_next.scl_prev = 1'b1;
			st_next.sda_prev = 1'b1;
			st_next.i2c = I_IDLE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			st_reg <= st_next;
		end
	end

	assign prim_bus.tx_valid = st_reg.sel_uart && prim_tx_valid_i;
	assign prim_bus.tx_data = prim_tx_data_i;
	assign spi_bus.tx_valid = !st_reg.sel_uart && prim_tx_valid_i;
	assign spi_bus.tx_data = prim_tx_data_i;
	assign sec_bus.tx_valid = sec_tx_valid_i;
	assign sec_bus.tx_data = sec_tx_data_i;

	hsps_uart u_prim_uart (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.en_i(st_reg.sel_uart),
		.rxd_i(st_reg.s2[SY_RXD]),
		.div_i(prim_div_i),
		.div_load_i(prim_div_load_i),
		.txd_o(u1_txd),
		.frame_err_o(prim_frame_err_o),
		.bus(prim_bus)
	);

	hsps_uart u_sec_uart (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.en_i(1'b1),
		.rxd_i(st_reg.s2[SY_SEC]),
		.div_i(sec_div_i),
		.div_load_i(sec_div_load_i),
		.txd_o(u2_txd),
		.frame_err_o(sec_frame_err_o),
		.bus(sec_bus)
	);

	hsps_spi_slave u_spi (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.en_i(!st_reg.sel_uart),
		.sck_i(st_reg.s2[SY_SCL]),
		.mosi_i(st_reg.s2[SY_RXD]),
		.cs_n_i(st_reg.s2[SY_SDA]),
		.miso_o(miso),
		.miso_oe_o(miso_oe),
		.bus(spi_bus)
	);

	// Shared pins: TXD/MISO push-pull, SCL/SCK and SDA/CS open drain in UART mode
	assign pin_txd_miso_o = st_reg.sel_uart ? u1_txd : miso;
	assign pin_txd_miso_oe_o = st_reg.sel_uart || miso_oe;
	assign pin_scl_sck_o = 1'b0;
	assign pin_scl_sck_oe_o = st_reg.sel_uart && st_reg.scl_oe;
	assign pin_sda_cs_o = 1'b0;
	assign pin_sda_cs_oe_o = st_reg.sel_uart && st_reg.sda_oe;
	assign sec_txd_o = u2_txd;
	assign prim_tx_ready_o = st_reg.sel_uart ? prim_bus.tx_ready : spi_bus.tx_ready;
	assign prim_rx_valid_o = st_reg.sel_uart ? prim_bus.rx_valid : spi_bus.rx_valid;
	assign prim_rx_data_o = st_reg.sel_uart ? prim_bus.rx_data : spi_bus.rx_data;
	assign sec_tx_ready_o = sec_bus.tx_ready;
	assign sec_rx_valid_o = sec_bus.rx_valid;
	assign sec_rx_data_o = sec_bus.rx_data;
	assign i2c_tx_ready_o = st_reg.i2c == I_LOAD;
	assign i2c_rx_valid_o = st_reg.rx_valid;
	assign i2c_rx_data_o = st_reg.rx_data;
	assign spi_mode_o = !st_reg.sel_uart;
	assign usb_enable_o = st_reg.usb_en;

	a_sel_fixed: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		$past(reset_n_i) |-> $stable(st_reg.sel_uart)) else $error("port select moved");
	a_spi_gated: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		st_reg.sel_uart |-> !spi_bus.rx_valid && !miso_oe) else $error("spi live in uart mode");
	a_i2c_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!st_reg.sel_uart |-> ##1 st_reg.i2c == I_IDLE && !pin_scl_sck_oe_o && !pin_sda_cs_oe_o)
		else $error("i2c active in spi mode");
	a_usb_on: assert property (@(posedge clk_i)
		$rose(reset_n_i) |-> usb_enable_o) else $error("usb port not offered");
	a_prim_uart: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		st_reg.sel_uart |-> pin_txd_miso_oe_o && pin_txd_miso_o == u1_txd)
		else $error("primary uart not on pins");
	a_stretch_max: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		st_reg.i2c == I_LOAD |-> st_reg.tmo <= TMO_LIMIT && pin_scl_sck_oe_o)
		else $error("stretch too long");
	a_setup_held: assert property (@(posedge clk_i) disable iff (!reset_n_i || !ce_i)
		$fell(st_reg.scl_oe) && st_reg.i2c == I_READ |->
		$stable(st_reg.sda_oe) && $past(st_reg.sda_oe, 2) == st_reg.sda_oe &&
		$past(st_reg.i2c, 3) == I_SETUP) else $error("setup before release too short");
endmodule : hsps_top

// ==== inc/hsps_pkg.sv ====
// Constants shared by the host serial port select block and its port engines.
// Assumes a 40 MHz core clock; UART divisors are whole core-clock cycles per bit.
package hsps_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int CLK_PERIOD_PS = 25000;
	localparam int UART_MIN_BPS = 9600;
	localparam int UART_MAX_BPS = 921600;
	localparam int UART_DEF_BPS = 38400;
	localparam int DIV_W = 16;
	localparam logic [3:0] UART_LAST_BIT = 4'h9;
	localparam logic [3:0] UART_FIRST_DATA = 4'h1;
	localparam logic [2:0] BYTE_MSB = 3'h7;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [7:0] IDLE_BYTE = 8'hff;
	localparam int SPI_MAX_SCK_HZ = 5_500_000;
	localparam int I2C_MAX_BPS = 400_000;
	localparam int I2C_STRETCH_MAX_MS = 20;
	localparam int I2C_STRETCH_CYC_DEF = CLK_HZ / 1000 * I2C_STRETCH_MAX_MS;
	localparam int I2C_SETUP_PS = 62500;
	localparam logic [3:0] I2C_SETUP_CYC = 4'((I2C_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [6:0] I2C_ADDR_DEF = 7'h10;

	// Nearest whole divisor keeps the transmit rate error smallest
	function automatic logic [DIV_W-1:0] hsps_div_of(input int bps);
		return DIV_W'((CLK_HZ + bps / 2) / bps);
	endfunction : hsps_div_of

	localparam logic [DIV_W-1:0] DIV_MIN = hsps_div_of(UART_MAX_BPS);
	localparam logic [DIV_W-1:0] DIV_MAX = hsps_div_of(UART_MIN_BPS);
	localparam logic [DIV_W-1:0] DIV_DEF = hsps_div_of(UART_DEF_BPS);

	function automatic logic [DIV_W-1:0] hsps_div_clamp(input logic [DIV_W-1:0] d);
		return (d < DIV_MIN) ? DIV_MIN : ((d > DIV_MAX) ? DIV_MAX : d);
	endfunction : hsps_div_clamp
endpackage : hsps_pkg

// ==== inc/hsps_byte_if.sv ====
// Byte stream between the top and one port engine.
// Assumes one clock domain; a transmit byte moves when tx_valid and tx_ready are both high.
`timescale 1ns/1ps
interface hsps_byte_if;
	logic tx_valid;
	logic [7:0] tx_data;
	logic tx_ready;
	logic rx_valid;
	logic [7:0] rx_data;
	modport port (input tx_valid, input tx_data, output tx_ready, output rx_valid,
		output rx_data);
	modport user (output tx_valid, output tx_data, input tx_ready, input rx_valid,
		input rx_data);
endinterface : hsps_byte_if

// ==== verilog/hsps_uart.sv ====
// Eight data bits, no parity, one stop bit UART engine with a clamped bit divisor.
// Assumes rxd_i is already synchronised to clk_i.
`timescale 1ns/1ps
module hsps_uart import hsps_pkg::*; (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic en_i,
	input wire logic rxd_i,
	input wire logic [DIV_W-1:0] div_i,
	input wire logic div_load_i,
	output logic txd_o,
	output logic frame_err_o,
	hsps_byte_if.port bus
);
	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic tx_busy;
		logic [DIV_W-1:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [9:0] tx_sh;
		logic txd;
		logic rx_busy;
		logic [DIV_W-1:0] rx_cnt;
		logic [3:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_prev;
		logic rx_valid;
		logic [7:0] rx_data;
		logic ferr;
	} hsps_uart_s;

	hsps_uart_s st_reg;
	hsps_uart_s st_next;

	always_comb begin
		st_next = st_reg;
		st_next.rx_valid = 1'b0;
		st_next.ferr = 1'b0;
		st_next.rx_prev = rxd_i;
		if (div_load_i) begin
			st_next.div = hsps_div_clamp(div_i);
		end
		// Transmit only: no request-to-send or clear-to-send is looked at or driven
		if (!en_i) begin
			st_next.tx_busy = 1'b0;
			st_next.txd = 1'b1;
		end else if (!st_reg.tx_busy) begin
			if (bus.tx_valid) begin
				st_next.tx_busy = 1'b1;
				st_next.tx_sh = {1'b1, bus.tx_data, 1'b0};
				st_next.txd = 1'b0;
				st_next.tx_bit = '0;
				st_next.tx_cnt = st_reg.div - 1'b1;
			end
		end else if (st_reg.tx_cnt == '0) begin
			if (st_reg.tx_bit == UART_LAST_BIT) begin
				st_next.tx_busy = 1'b0;
				st_next.txd = 1'b1;
			end else begin
				st_next.tx_bit = st_reg.tx_bit + 1'b1;
				st_next.tx_sh = {1'b1, st_reg.tx_sh[9:1]};
				st_next.txd = st_reg.tx_sh[1];
				st_next.tx_cnt = st_reg.div - 1'b1;
			end
		end else begin
			st_next.tx_cnt = st_reg.tx_cnt - 1'b1;
		end
		// Receive: start edge, then every bit sampled at its centre
		if (!en_i) begin
			st_next.rx_busy = 1'b0;
		end else if (!st_reg.rx_busy) begin
			if (st_reg.rx_prev && !rxd_i) begin
				st_next.rx_busy = 1'b1;
				st_next.rx_bit = '0;
				st_next.rx_cnt = st_reg.div >> 1;
			end
		end else if (st_reg.rx_cnt != '0) begin
			st_next.rx_cnt = st_reg.rx_cnt - 1'b1;
		end else if (st_reg.rx_bit == '0) begin
			// A start bit that is gone at its centre was a glitch
			st_next.rx_busy = !rxd_i;
			st_next.rx_bit = UART_FIRST_DATA;
			st_next.rx_cnt = st_reg.div - 1'b1;
		end else if (st_reg.rx_bit != UART_LAST_BIT) begin
			st_next.rx_sh = {rxd_i, st_reg.rx_sh[7:1]};
			st_next.rx_bit = st_reg.rx_bit + 1'b1;
			st_next.rx_cnt = st_reg.div - 1'b1;
		end else begin
			st_next.rx_busy = 1'b0;
			st_next.rx_valid = rxd_i;
			st_next.ferr = !rxd_i;
			st_next.rx_data = st_reg.rx_sh;
		end
		if (!reset_n_i) begin
			st_next = '0;
			st_next.div = DIV_DEF;
			st_next.txd = 1'b1;
			st_next.tx_sh = '1;
			st_next.rx_prev = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			st_reg <= st_next;
		end
	end

	assign txd_o = st_reg.txd;
	assign frame_err_o = st_reg.ferr;
	assign bus.tx_ready = en_i && !st_reg.tx_busy;
	assign bus.rx_valid = st_reg.rx_valid;
	assign bus.rx_data = st_reg.rx_data;

	a_div_range: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		st_reg.div >= DIV_MIN && st_reg.div <= DIV_MAX) else $error("divisor out of range");
	a_div_default: assert property (@(posedge clk_i)
		$rose(reset_n_i) |-> st_reg.div == DIV_DEF) else $error("divisor not default");
	a_tx_bit_edge: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		$changed(txd_o) |-> ($past(st_reg.tx_cnt) == '0 || !$past(st_reg.tx_busy)))
		else $error("tx edge off bit boundary");
	a_rx_centre: assert property (@(posedge clk_i) disable iff (!reset_n_i || !ce_i)
		$rose(st_reg.rx_busy) |-> st_reg.rx_cnt == (st_reg.div >> 1) && !$past(rxd_i))
		else $error("rx start not centred");
endmodule : hsps_uart

// ==== verilog/hsps_spi_slave.sv ====
// SPI slave, clock polarity 0 and phase 0, sampled by the core clock.
// Assumes sck_i, mosi_i and cs_n_i are already synchronised and the master keeps SCK slow.
`timescale 1ns/1ps
module hsps_spi_slave import hsps_pkg::*; (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic en_i,
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic cs_n_i,
	output logic miso_o,
	output logic miso_oe_o,
	hsps_byte_if.port bus
);
	typedef struct packed {
		logic sck_prev;
		logic cs_prev;
		logic [2:0] bit_cnt;
		logic [7:0] rx_sh;
		logic [7:0] tx_sh;
		logic miso;
		logic oe;
		logic rx_valid;
		logic [7:0] rx_data;
	} hsps_spi_s;

	hsps_spi_s st_reg;
	hsps_spi_s st_next;
	logic sel;
	logic rise;
	logic fall;
	logic load;

	always_comb begin
		sel = en_i && !cs_n_i;
		rise = sel && sck_i && !st_reg.sck_prev;
		fall = sel && !sck_i && st_reg.sck_prev;
		load = (sel && st_reg.cs_prev) || (fall && st_reg.bit_cnt == '0);
		st_next = st_reg;
		st_next.sck_prev = sck_i;
		st_next.cs_prev = cs_n_i || !en_i;
		st_next.rx_valid = 1'b0;
		st_next.oe = sel;
		if (!sel) begin
			st_next.bit_cnt = '0;
		end
		if (rise) begin
			st_next.rx_sh = {st_reg.rx_sh[6:0], mosi_i};
			st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
			if (st_reg.bit_cnt == BYTE_MSB) begin
				st_next.rx_valid = 1'b1;
				st_next.rx_data = {st_reg.rx_sh[6:0], mosi_i};
			end
		end
		if (load) begin
			st_next.tx_sh = bus.tx_valid ? bus.tx_data : IDLE_BYTE;
			st_next.miso = bus.tx_valid ? bus.tx_data[BYTE_MSB] : IDLE_BYTE[BYTE_MSB];
		end else if (fall) begin
			st_next.tx_sh = {st_reg.tx_sh[6:0], 1'b1};
			st_next.miso = st_reg.tx_sh[6];
		end
		if (!reset_n_i) begin
			st_next = '0;
			st_next.cs_prev = 1'b1;
			st_next.miso = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			st_reg <= st_next;
		end
	end

	assign miso_o = st_reg.miso;
	assign miso_oe_o = st_reg.oe;
	assign bus.tx_ready = load;
	assign bus.rx_valid = st_reg.rx_valid;
	assign bus.rx_data = st_reg.rx_data;

	a_miso_released: assert property (@(posedge clk_i) disable iff (!reset_n_i || !ce_i)
		$past(cs_n_i || !en_i) |-> !miso_oe_o) else $error("miso driven while deselected");
	a_miso_on_fall: assert property (@(posedge clk_i) disable iff (!reset_n_i || !ce_i)
		$changed(miso_o) |-> $past(fall || load)) else $error("miso moved off falling edge");
endmodule : hsps_spi_slave

// ==== verif/hsps_host_model.sv ====
// Host processor model: UART line and SPI master on the shared port pins.
// Assumes the bench calls its tasks one at a time; idle lines sit at the pulled-up level, except SPI SCK, which idles low.
`timescale 1ns/1ps
module hsps_host_model (
	input wire logic clk_i,
	input wire logic spi_sel_i,
	input wire logic dev_txd_i,
	input wire logic sda_i,
	output logic line_o,
	output logic sck_o,
	output logic cs_n_o
);
	logic sck_reg;
	logic scl_reg;
	initial begin
		line_o = 1'b1;
		cs_n_o = 1'b1;
		sck_reg = 1'b0;
		scl_reg = 1'b1;
	end
	// Outside SPI routing the clock pin is SCL, idle at its pulled-up level
	assign sck_o = spi_sel_i ? sck_reg : scl_reg;

	// Fast-mode write of an address byte and a data byte; ack holds SDA at both ack bits
	task automatic i2c_write(input logic [15:0] w, output logic [1:0] ack);
		logic [17:0] f;
		f = {w[15:8], 1'b1, w[7:0], 1'b1};
		ack = 2'b11;
		cs_n_o = 1'b0;
		#600;
		for (int i = 17; i >= 0; i--) begin
			scl_reg = 1'b0;
			#600 cs_n_o = f[i];
			#700 scl_reg = 1'b1;
			#650;
			if (i == 9) ack[1] = sda_i;
			if (i == 0) ack[0] = sda_i;
			#650;
		end
		scl_reg = 1'b0;
		#600 cs_n_o = 1'b0;
		#700 scl_reg = 1'b1;
		#600 cs_n_o = 1'b1;
		#1300;
	endtask : i2c_write

	task automatic uart_send(input logic [7:0] d, input int bit_ns, input logic stop);
		logic [9:0] f;
		f = {stop, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_o = f[i];
			#(bit_ns);
		end
		line_o = 1'b1;
	endtask : uart_send

	// Reads happen at clock edges only, so the start bit length is exact
	task automatic uart_recv(input int div, output logic [7:0] d, output int low, output bit ok);
		ok = 1'b0;
		low = 0;
		d = 8'h00;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			if (dev_txd_i === 1'b0) break;
		end
		if (dev_txd_i === 1'b0) begin
			while (dev_txd_i === 1'b0 && low < 5000) begin
				low++;
				@(posedge clk_i);
			end
			repeat (div / 2) @(posedge clk_i);
			for (int i = 0; i < 8; i++) begin
				d[i] = dev_txd_i;
				repeat (div) @(posedge clk_i);
			end
			ok = (dev_txd_i === 1'b1);
		end
	endtask : uart_recv

	// Mode zero at 5 MHz, MSB first
	task automatic spi_xfer(input logic [7:0] mo, output logic [7:0] mi);
		cs_n_o = 1'b0;
		#200;
		for (int i = 7; i >= 0; i--) begin
			line_o = mo[i];
			#100 sck_reg = 1'b1;
			mi[i] = dev_txd_i;
			#100 sck_reg = 1'b0;
		end
		#100 cs_n_o = 1'b1;
		line_o = 1'b1;
	endtask : spi_xfer
endmodule : hsps_host_model

// ==== verif/hsps_top_tb.sv ====
// Self-checking bench for the host serial port select block.
// Assumes the host model drives the shared pins; open-drain pins resolve with pull-ups.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; \
	if ((a) !== (b)) begin num_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module hsps_top_tb import hsps_pkg::*;;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic host_sel_i = 1'b1;
	logic [DIV_W-1:0] prim_div_i = '0;
	logic [DIV_W-1:0] sec_div_i = '0;
	logic prim_div_load_i = 1'b0;
	logic sec_div_load_i = 1'b0;
	logic prim_tx_valid_i = 1'b0;
	logic sec_tx_valid_i = 1'b0;
	logic [7:0] prim_tx_data_i = 8'h00;
	logic [7:0] sec_tx_data_i = 8'h00;
	logic txd_miso, txd_oe, scl_o, scl_oe, sda_o, sda_oe, sec_txd, prim_ready, prim_rx_valid;
	logic prim_fe, sec_ready, sec_rx_valid, sec_fe, i2c_ready, i2c_rx_valid, spi_mode, usb_en;
	logic [7:0] prim_rx_data, sec_rx_data, i2c_rx_data;
	logic line, sck, cs_n;
	int num_errors = 0;
	int num_checks = 0;
	wire miso_line = txd_oe ? txd_miso : 1'b1;

	always #12.5 clk_i = ~clk_i;

	hsps_host_model host_u (.clk_i(clk_i), .spi_sel_i(spi_mode), .dev_txd_i(miso_line),
		.sda_i(cs_n & ~sda_oe),
		.line_o(line), .sck_o(sck), .cs_n_o(cs_n));

	hsps_top #(.STRETCH_CYC(200)) dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
		.host_sel_i(host_sel_i), .pin_rxd_mosi_i(line), .pin_txd_miso_o(txd_miso),
		.pin_txd_miso_oe_o(txd_oe), .pin_scl_sck_i(sck & ~scl_oe), .pin_scl_sck_o(scl_o),
		.pin_scl_sck_oe_o(scl_oe), .pin_sda_cs_i(cs_n & ~sda_oe), .pin_sda_cs_o(sda_o),
		.pin_sda_cs_oe_o(sda_oe), .sec_rxd_i(sec_txd), .sec_txd_o(sec_txd),
		.prim_div_i(prim_div_i), .prim_div_load_i(prim_div_load_i), .sec_div_i(sec_div_i),
		.sec_div_load_i(sec_div_load_i), .prim_tx_valid_i(prim_tx_valid_i),
		.prim_tx_data_i(prim_tx_data_i), .prim_tx_ready_o(prim_ready),
		.prim_rx_valid_o(prim_rx_valid), .prim_rx_data_o(prim_rx_data),
		.prim_frame_err_o(prim_fe), .sec_tx_valid_i(sec_tx_valid_i),
		.sec_tx_data_i(sec_tx_data_i), .sec_tx_ready_o(sec_ready),
		.sec_rx_valid_o(sec_rx_valid), .sec_rx_data_o(sec_rx_data), .sec_frame_err_o(sec_fe),
		.i2c_tx_valid_i(1'b0), .i2c_tx_data_i(8'h00), .i2c_tx_ready_o(i2c_ready),
		.i2c_rx_valid_o(i2c_rx_valid), .i2c_rx_data_o(i2c_rx_data), .spi_mode_o(spi_mode),
		.usb_enable_o(usb_en));

	task automatic complete_run();
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : complete_run

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask : tick

	// A pulse stands one cycle, so it is looked at just after each edge
	task automatic wait_hi(ref logic s, input int lim);
		for (int i = 0; i < lim; i++) begin
			@(posedge clk_i);
			#1;
			if (s === 1'b1) begin
				num_checks++;
				return;
			end
		end
		num_errors++;
		$display("BAD t=%0t got=%h exp=%h", $time, s, 1'b1);
		complete_run();
	endtask : wait_hi

	task automatic do_reset(input logic sel);
		reset_n_i = 1'b0;
		host_sel_i = sel;
		tick(16);
		reset_n_i = 1'b1;
		tick(6);
	endtask : do_reset

	task automatic send_byte(ref logic v, ref logic [7:0] dat, ref logic rdy, input logic [7:0] d);
		dat = d;
		v = 1'b1;
		for (int i = 0; i < 20 && rdy !== 1'b1; i++) tick(1);
		tick(1);
		v = 1'b0;
	endtask : send_byte

	task automatic t_prim_tx(input int div, input logic [7:0] d);
		logic [7:0] got;
		int low;
		bit ok;
		send_byte(prim_tx_valid_i, prim_tx_data_i, prim_ready, d);
		host_u.uart_recv(div, got, low, ok);
		`CHK(low, div)
		`CHK(got, d)
		`CHK(ok, 1'b1)
	endtask : t_prim_tx

	task automatic t_prim_rx(input int bit_ns, input logic stop, input logic [7:0] d);
		fork
			host_u.uart_send(d, bit_ns, stop);
			if (stop) wait_hi(prim_rx_valid, 12000);
			else wait_hi(prim_fe, 12000);
		join
		if (stop) `CHK(prim_rx_data, d)
		tick(1);
	endtask : t_prim_rx

	task automatic t_clamp();
		prim_div_i = 16'h0000;
		prim_div_load_i = 1'b1;
		tick(1);
		prim_div_load_i = 1'b0;
		t_prim_tx(43, 8'h5b);
	endtask : t_clamp

	task automatic t_sec_loop();
		sec_div_i = 16'h0064;
		sec_div_load_i = 1'b1;
		tick(1);
		sec_div_load_i = 1'b0;
		send_byte(sec_tx_valid_i, sec_tx_data_i, sec_ready, 8'h69);
		wait_hi(sec_rx_valid, 2000);
		`CHK(sec_rx_data, 8'h69)
	endtask : t_sec_loop

	task automatic t_i2c();
		logic [1:0] ack;
		fork
			host_u.i2c_write({I2C_ADDR_DEF, 1'b0, 8'h4e}, ack);
			wait_hi(i2c_rx_valid, 2400);
		join
		`CHK(ack, 2'b00)
		`CHK(i2c_rx_data, 8'h4e)
		host_u.i2c_write({~I2C_ADDR_DEF, 1'b0, 8'h4e}, ack);
		`CHK(ack, 2'b11)
	endtask : t_i2c

	task automatic t_spi();
		logic [7:0] got;
		do_reset(1'b0);
		`CHK(spi_mode, 1'b1)
		`CHK({scl_oe, sda_oe}, 2'b00)
		`CHK(txd_oe, 1'b0)
		prim_tx_data_i = 8'hc3;
		prim_tx_valid_i = 1'b1;
		fork
			host_u.spi_xfer(8'h96, got);
			wait_hi(prim_rx_valid, 200);
		join
		tick(1);
		prim_tx_valid_i = 1'b0;
		`CHK(got, 8'hc3)
		`CHK(prim_rx_data, 8'h96)
		host_sel_i = 1'b1;
		tick(10);
		`CHK(spi_mode, 1'b1)
		`CHK(scl_oe, 1'b0)
	endtask : t_spi

	initial begin
		#2_400_000;
		num_errors++;
		complete_run();
	end

	initial begin
		do_reset(1'b1);
		`CHK(usb_en, 1'b1)
		`CHK(spi_mode, 1'b0)
		`CHK(txd_oe, 1'b1)
		`CHK({scl_oe, sda_oe, sec_txd}, 3'b001)
		t_prim_tx(1042, 8'ha5);
		t_prim_rx(25399, 1'b1, 8'h3c);
		t_prim_rx(26701, 1'b1, 8'hc5);
		t_prim_rx(26050, 1'b0, 8'h81);
		t_clamp();
		t_sec_loop();
		t_i2c();
		t_spi();
		complete_run();
	end
endmodule : hsps_top_tb
